// *** fcs_flash_model.sv ***
// Behavioural flash array on the far side of the sequencer
`timescale 1ns/1ns
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [31:0] PROG_BYTES = 32'h0000_0100
) (
    input  wire logic                   clk,
    input  wire fcs_pkg::fcs_flash_req_s flashReq,
    input  wire logic [3:0]             lat,
    input  wire logic [31:0]            stuckAddr,
    input  wire logic [1:0]             eccCode,
    output fcs_pkg::fcs_flash_rsp_s     flashRsp
);
    // ****************************************
    // Array contents and answer timing
    // ****************************************
    logic [63:0] mem [logic [28:0]];
    logic [63:0] pend;
    logic [1:0]  pendEcc;
    logic [3:0]  cnt;

    // Unwritten words read as erased
    function automatic logic [63:0] rdw(input logic [31:0] a);
        return mem.exists(a[31:3]) ? mem[a[31:3]] : '1;
    endfunction : rdw

    // Erase a byte range, one word left stuck when asked
    task automatic erase_range(input logic [31:0] a, input int n);
        for (int i = 0; i < n; i += 8) begin
            if (a + 32'(i) != stuckAddr) mem[29'((a + 32'(i)) >> 3)] = '1;
        end
    endtask : erase_range

    initial begin
        flashRsp = '0;
        cnt = '0;
    end

    // One operation at a time, done after lat cycles
    always @(posedge clk) begin
        flashRsp.done <= 1'b0;
        if (cnt == 4'h1) begin
            flashRsp.done  <= 1'b1;
            flashRsp.rdata <= pend;
            flashRsp.ecc   <= pendEcc;
        end else begin
            flashRsp.rdata <= ~flashRsp.rdata;  // Stale data never holds
        end
        if (cnt != 4'h0) cnt <= cnt - 4'h1;
        if (flashReq.rd | flashReq.prog | flashReq.erase) begin
            cnt     <= lat;
            pend    <= rdw(flashReq.addr);
            pendEcc <= flashReq.eccOn ? eccCode : 2'h0;
            if (flashReq.prog) mem[flashReq.addr[31:3]] = rdw(flashReq.addr) & flashReq.wdata;
            if (flashReq.erase & flashReq.mass) begin
                erase_range(flashReq.addr, flashReq.addr == FCS_DATA_BASE ? FCS_DHALF_BYTES : int'(PROG_BYTES));
            end else if (flashReq.erase) begin
                erase_range(flashReq.addr, FCS_PAGE_BYTES);
            end
        end
    end
endmodule : fcs_flash_model

// *** fcs_pkg.sv ***
// Package of constants and types for the flash command sequencer
package fcs_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] FCS_CTRL_OFS   = 8'h04;
    localparam logic [7:0] FCS_CMD_OFS    = 8'h08;
    localparam logic [7:0] FCS_WADDR_OFS  = 8'h0c;
    localparam logic [7:0] FCS_WDATL_OFS  = 8'h10;
    localparam logic [7:0] FCS_WDATH_OFS  = 8'h14;
    localparam logic [7:0] FCS_PSTART_OFS = 8'h18;
    localparam logic [7:0] FCS_PEND_OFS   = 8'h1c;
    localparam logic [7:0] FCS_KEY_OFS    = 8'h20;
    localparam logic [7:0] FCS_STAT_OFS   = 8'h24;
    localparam logic [7:0] FCS_SIGN_OFS   = 8'h28;
    localparam logic [7:0] FCS_PECC_OFS   = 8'h30;
    localparam logic [7:0] FCS_DECC_OFS   = 8'h34;

    // ****************************************
    // Command codes, keys, field positions
    // ****************************************
    localparam logic [3:0]  FCS_CMD_IDLE  = 4'h0;
    localparam logic [3:0]  FCS_CMD_PAGE  = 4'h1;
    localparam logic [3:0]  FCS_CMD_SIGN  = 4'h2;
    localparam logic [3:0]  FCS_CMD_WRITE = 4'h4;
    localparam logic [3:0]  FCS_CMD_MPROG = 4'h5;
    localparam logic [3:0]  FCS_CMD_MDATA = 4'h6;
    localparam logic [15:0] FCS_KEY1      = 16'hf456;
    localparam logic [15:0] FCS_KEY2      = 16'hf123;
    localparam logic [15:0] FCS_CTRL_RST  = 16'h0010;
    localparam int          FCS_CTRL_FAILIE = 2;
    localparam logic [1:0]  FCS_RES_OK    = 2'h0;
    localparam logic [1:0]  FCS_RES_VERR  = 2'h2;
    localparam int          FCS_ST_BUSY   = 0;
    localparam int          FCS_ST_DONE   = 2;
    localparam int          FCS_ST_RES    = 4;
    localparam int          FCS_ST_ECC    = 7;
    localparam logic [63:0] FCS_ERASED    = 64'h00ff_ffff_ffff_ffff;
    localparam logic [31:0] FCS_ERASED_P  = 32'hffff_ffff;
    localparam logic [31:0] FCS_DATA_BASE = 32'h0004_0000;
    localparam int          FCS_PAGE_BYTES   = 64;
    localparam int          FCS_WORD_BYTES   = 8;
    localparam int          FCS_DHALF_BYTES  = 2048;
    localparam logic [31:0] FCS_PROT_ADDR    = 32'h0003_ffc0;
    localparam logic [31:0] FCS_UKEY_ADDR    = 32'h0003_ffc8;

    // Sequencer states
    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_ERASE,
        FCS_ERWAIT,
        FCS_READ,
        FCS_RDWAIT,
        FCS_PROG,
        FCS_PGWAIT
    } fcs_state_e;

    // Flash array request bundle
    typedef struct packed {
        logic        rd;
        logic        prog;
        logic        erase;
        logic        mass;
        logic        eccOn;
        logic [31:0] addr;
        logic [63:0] wdata;
    } fcs_flash_req_s;

    // Flash array answer bundle
    typedef struct packed {
        logic        done;
        logic [63:0] rdata;
        logic [1:0]  ecc;
    } fcs_flash_rsp_s;

endpackage : fcs_pkg

// *** fcs_sequencer.sv ***
// Flash command sequencer with Wishbone register slave
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Command 0001 erases the page at page_start_addr_reg.
// - After page erase every word is read back; a mismatch in the low 32 bits flags verify error.
// - Error correction off during page and mass erases, verify included.
// - Key f456 then f123 unlocks protected commands.
// - Command 0010 signs pages start..end, result in signature_result_reg.
// - Last four bytes of last signed page hold the stored signature.
// - Signature reads always check error correction.
// - Signature ECC errors go to status bits 8:7.
// - Signature ECC errors leave ECC log registers untouched.
// - Signature ECC error interrupts only if control bit 2 set.
// - Command 0100 programs keyhole data at keyhole address.
// - Only protection and user key locations need the key to write.
// - Command 0101 erases program flash, verifies the low 32 bits of each word are all ones.
// - Command 0110 erases first 2048 data bytes, verifies the low 56 bits of each word are all ones.
// - Protected command without unlock does nothing.
// - Verify or signature mismatch sets result field to 10.
module fcs_sequencer #(
    parameter logic [31:0] PROG_BYTES = 32'h0003_0000
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    output fcs_pkg::fcs_flash_req_s     flashReq,
    input  wire fcs_pkg::fcs_flash_rsp_s flashRsp,
    output logic                        failIrq
);
    import fcs_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0]     rstSync;
        fcs_state_e     st;
        logic [3:0]     cmd;
        logic [15:0]    ctrl;
        logic [1:0]     keyStage;
        logic [31:0]    wAddr;
        logic [63:0]    wData;
        logic [31:0]    pStart;
        logic [31:0]    pEnd;
        logic [31:0]    cur;
        logic [31:0]    last;
        logic [31:0]    sign;
        logic [1:0]     result;
        logic [1:0]     eccSt;
        logic           done;
        logic [31:0]    peccLog;
        logic [31:0]    deccLog;
        logic [31:0]    rdData;
        logic           ack;
        logic           irq;
        fcs_flash_req_s req;
    } fcs_regs_s;

    fcs_regs_s r_reg;
    fcs_regs_s r_next;
    logic      rstn;
    logic      wbReq;
    logic [63:0] expect64;
    logic        isSign;
    logic        isMass;

    assign rstn     = r_reg.rstSync[1];
    assign wb_dat_o = r_reg.rdData;
    assign wb_ack_o = r_reg.ack;
    assign flashReq = r_reg.req;
    assign failIrq  = r_reg.irq;
    assign wbReq    = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    assign isSign   = (r_reg.cmd == FCS_CMD_SIGN);
    assign isMass   = (r_reg.cmd == FCS_CMD_MPROG) | (r_reg.cmd == FCS_CMD_MDATA);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [31:0] st32;
        logic        keyOk;
        logic        protLoc;
        logic [3:0]  wcmd;
        st32  = '0;
        r_next = r_reg;
        r_next.rstSync = {r_reg.rstSync[0], 1'b1};
        r_next.ack = 1'b0;
        r_next.irq = 1'b0;
        keyOk = (r_reg.keyStage == 2'd2);
        wcmd  = wb_dat_i[3:0];
        protLoc = (r_reg.wAddr == FCS_PROT_ADDR) | (r_reg.wAddr == FCS_UKEY_ADDR);
        expect64 = (r_reg.cmd == FCS_CMD_MDATA) ? FCS_ERASED : {32'h0, FCS_ERASED_P};
        // Status word
        st32[FCS_ST_BUSY]             = (r_reg.st != FCS_IDLE);
        st32[FCS_ST_DONE]             = r_reg.done;
        st32[FCS_ST_RES +: 2]         = r_reg.result;
        st32[FCS_ST_ECC +: 2]         = r_reg.eccSt;
        // Bus slave: one-cycle registered answer
        if (wbReq) begin
            r_next.ack = 1'b1;
            r_next.rdData = '0;
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    FCS_CTRL_OFS:   r_next.ctrl = {11'h0, wb_dat_i[4:0] & 5'h17};
                    FCS_WADDR_OFS:  r_next.wAddr = {9'h0, wb_dat_i[22:3], 3'h0};
                    FCS_WDATL_OFS:  r_next.wData[31:0] = wb_dat_i;
                    FCS_WDATH_OFS:  r_next.wData[63:32] = wb_dat_i;
                    FCS_PSTART_OFS: r_next.pStart = {9'h0, wb_dat_i[22:6], 6'h0};
                    FCS_PEND_OFS:   r_next.pEnd = {9'h0, wb_dat_i[22:6], 6'h0};
                    FCS_KEY_OFS: begin
                        // Ordered two-word unlock
                        if (wb_dat_i[15:0] == FCS_KEY1)
                            r_next.keyStage = 2'd1;
                        else if (wb_dat_i[15:0] == FCS_KEY2 && r_reg.keyStage == 2'd1)
                            r_next.keyStage = 2'd2;
                        else
                            r_next.keyStage = 2'd0;
                    end
                    FCS_CMD_OFS: begin
                        r_next.keyStage = 2'd0;
                        // Unkeyed protected codes leave cmd and result untouched
                        if (r_reg.st == FCS_IDLE && wcmd != FCS_CMD_IDLE
                            && (keyOk || (wcmd == FCS_CMD_WRITE && !protLoc))) begin
                            r_next.cmd = wcmd;
                            r_next.result = FCS_RES_OK;
                            r_next.req.eccOn = 1'b1;
                            unique case (wcmd)
                                FCS_CMD_PAGE: if (keyOk) begin
                                    r_next.cur  = r_reg.pStart;
                                    r_next.last = r_reg.pStart + 32'(FCS_PAGE_BYTES - FCS_WORD_BYTES);
                                    r_next.req.mass = 1'b0;
                                    r_next.req.eccOn = 1'b0;
                                    r_next.st = FCS_ERASE;
                                end
                                FCS_CMD_MPROG: if (keyOk) begin
                                    r_next.cur  = '0;
                                    r_next.last = PROG_BYTES - 32'(FCS_WORD_BYTES);
                                    r_next.req.mass = 1'b1;
                                    r_next.req.eccOn = 1'b0;
                                    r_next.st = FCS_ERASE;
                                end
                                FCS_CMD_MDATA: if (keyOk) begin
                                    r_next.cur  = FCS_DATA_BASE;
                                    r_next.last = FCS_DATA_BASE + 32'(FCS_DHALF_BYTES - FCS_WORD_BYTES);
                                    r_next.req.mass = 1'b1;
                                    r_next.req.eccOn = 1'b0;
                                    r_next.st = FCS_ERASE;
                                end
                                FCS_CMD_SIGN: if (keyOk) begin
                                    r_next.cur   = r_reg.pStart;
                                    r_next.last  = r_reg.pEnd + 32'(FCS_PAGE_BYTES - FCS_WORD_BYTES);
                                    r_next.sign  = '0;
                                    r_next.eccSt = 2'h0;
                                    r_next.req.eccOn = 1'b1;
                                    r_next.st = FCS_READ;
                                end
                                FCS_CMD_WRITE: if (keyOk || !protLoc) begin
                                    r_next.st = FCS_PROG;
                                end
                                default: ;
                            endcase
                        end
                    end
                    default: ;
                endcase
            end else begin
                unique case (wb_adr_i)
                    FCS_CTRL_OFS:   r_next.rdData = {16'h0, r_reg.ctrl};
                    FCS_CMD_OFS:    r_next.rdData = {28'h0, r_reg.cmd};
                    FCS_WADDR_OFS:  r_next.rdData = r_reg.wAddr;
                    FCS_WDATL_OFS:  r_next.rdData = r_reg.wData[31:0];
                    FCS_WDATH_OFS:  r_next.rdData = r_reg.wData[63:32];
                    FCS_PSTART_OFS: r_next.rdData = r_reg.pStart;
                    FCS_PEND_OFS:   r_next.rdData = r_reg.pEnd;
                    FCS_STAT_OFS: begin
                        r_next.rdData = st32;
                        r_next.done = 1'b0; // Cleared by read
                    end
                    FCS_SIGN_OFS:   r_next.rdData = r_reg.sign;
                    FCS_PECC_OFS:   r_next.rdData = r_reg.peccLog;
                    FCS_DECC_OFS:   r_next.rdData = r_reg.deccLog;
                    default:        r_next.rdData = '0;
                endcase
            end
        end
        // Flash sequencing
        r_next.req.rd = 1'b0;
        r_next.req.prog = 1'b0;
        r_next.req.erase = 1'b0;
        unique case (r_reg.st)
            FCS_IDLE: ;
            FCS_ERASE: begin
                r_next.req.erase = 1'b1;
                r_next.req.addr = r_reg.cur;
                r_next.st = FCS_ERWAIT;
            end
            FCS_ERWAIT: if (flashRsp.done) r_next.st = FCS_READ;
            FCS_READ: begin
                r_next.req.rd = 1'b1;
                r_next.req.addr = r_reg.cur;
                r_next.st = FCS_RDWAIT;
            end
            FCS_RDWAIT: if (flashRsp.done) begin
                if (isSign) begin
                    // Stored signature half is excluded from the sum
                    if (r_reg.cur != r_reg.last) begin
                        r_next.sign = r_reg.sign ^ flashRsp.rdata[31:0] ^ flashRsp.rdata[63:32];
                    end else begin
                        // Low half of the last word still counts
                        r_next.sign = r_reg.sign ^ flashRsp.rdata[31:0];
                        if ((r_reg.sign ^ flashRsp.rdata[31:0]) != flashRsp.rdata[63:32])
                            r_next.result = FCS_RES_VERR;
                    end
                    if (flashRsp.ecc != 2'h0) begin
                        r_next.eccSt = r_reg.eccSt | flashRsp.ecc;
                        r_next.irq = r_reg.ctrl[FCS_CTRL_FAILIE];
                    end
                end else if ((flashRsp.rdata & expect64) != expect64) begin
                    r_next.result = FCS_RES_VERR;
                end
                if (r_reg.cur == r_reg.last) begin
                    r_next.st = FCS_IDLE;
                    r_next.done = 1'b1;
                    r_next.cmd = FCS_CMD_IDLE;
                    r_next.req.eccOn = 1'b1;
                end else begin
                    r_next.cur = r_reg.cur + 32'(FCS_WORD_BYTES);
                    r_next.st = FCS_READ;
                end
            end
            FCS_PROG: begin
                r_next.req.prog = 1'b1;
                r_next.req.addr = r_reg.wAddr;
                r_next.req.wdata = r_reg.wData;
                r_next.st = FCS_PGWAIT;
            end
            FCS_PGWAIT: if (flashRsp.done) begin
                r_next.st = FCS_IDLE;
                r_next.done = 1'b1;
                r_next.cmd = FCS_CMD_IDLE;
            end
            default: r_next.st = FCS_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else if (!rstn) begin
            r_reg <= '0;
            r_reg.rstSync <= {r_reg.rstSync[0], 1'b1};
            r_reg.ctrl <= FCS_CTRL_RST;
            r_reg.req.eccOn <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_erase_ecc_off: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st != FCS_IDLE && isMass) |-> !r_reg.req.eccOn) else $error("ecc on in mass erase");
    chk_sign_ecc_on: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st != FCS_IDLE && isSign) |-> r_reg.req.eccOn) else $error("ecc off in sign");
    chk_idle_nothing: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st == FCS_IDLE) |=> !r_reg.req.erase && !r_reg.req.rd) else $error("idle started op");
    chk_nokey_ignore: assert property (@(posedge clk) disable iff (!rstn)
        (wbReq && wb_we_i && wb_adr_i == FCS_CMD_OFS && wb_dat_i[3:0] == FCS_CMD_PAGE
         && r_reg.keyStage != 2'd2 && r_reg.st == FCS_IDLE) |=> r_reg.st == FCS_IDLE) else $error("unkeyed erase");
    chk_key_start: assert property (@(posedge clk) disable iff (!rstn)
        (wbReq && wb_we_i && wb_adr_i == FCS_CMD_OFS && wb_dat_i[3:0] == FCS_CMD_PAGE
         && r_reg.keyStage == 2'd2 && r_reg.st == FCS_IDLE) |=> ##1 r_reg.req.erase) else $error("erase not begun");
    chk_page_addr: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.req.erase && !r_reg.req.mass) |-> r_reg.req.addr[5:0] == 6'h0) else $error("bad page addr");
    chk_verify_err: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st == FCS_RDWAIT && flashRsp.done && !isSign && (flashRsp.rdata & expect64) != expect64)
        |=> r_reg.result == FCS_RES_VERR) else $error("verify error lost");
    chk_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
        failIrq |-> $past(r_reg.ctrl[FCS_CTRL_FAILIE])) else $error("irq while disabled");
    chk_write_prog: assert property (@(posedge clk) disable iff (!rstn)
        r_reg.req.prog |-> $past(r_reg.st) == FCS_PROG) else $error("stray program");
    chk_page_ecc_off: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st != FCS_IDLE && r_reg.cmd == FCS_CMD_PAGE) |-> !r_reg.req.eccOn) else $error("ecc on in page erase");
    chk_sign_verr: assert property (@(posedge clk) disable iff (!rstn)
        (r_reg.st == FCS_RDWAIT && flashRsp.done && isSign && r_reg.cur == r_reg.last
         && (r_reg.sign ^ flashRsp.rdata[31:0]) != flashRsp.rdata[63:32]) |=> r_reg.result == FCS_RES_VERR)
        else $error("sign mismatch lost");

endmodule : fcs_sequencer

// *** fcs_sequencer_bench.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ns
module fcs_sequencer_bench;
    import fcs_pkg::*;
    // ****************************************
    // Signals, design and flash model
    // ****************************************
    localparam logic [31:0] PB = 32'h0000_0100;
    localparam logic [31:0] DB = FCS_DATA_BASE;
    logic           clk, resetn, cyc, stb, we, wbAck, failIrq, chkEcc, expEcc;
    logic [7:0]     adr;
    logic [31:0]    wdat, wbDat, q, st, sg;
    logic [3:0]     lat;
    logic [31:0]    stuckAddr;
    logic [1:0]     eccCode;
    fcs_flash_req_s flashReq;
    fcs_flash_rsp_s flashRsp;
    int             errCount, compares, eraseCnt, readCnt, irqCnt, cycles, r0, n0;

    fcs_sequencer #(.PROG_BYTES(PB)) u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wbDat), .wb_ack_o(wbAck),
        .flashReq(flashReq), .flashRsp(flashRsp), .failIrq(failIrq));
    fcs_flash_model #(.PROG_BYTES(PB)) u_mem (.clk(clk), .flashReq(flashReq), .lat(lat),
        .stuckAddr(stuckAddr), .eccCode(eccCode), .flashRsp(flashRsp));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Bus, compare and command tasks
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle held until ack is sampled
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk);
        while (wbAck !== 1'b1) @(posedge clk);
        r = wbDat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wbx

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wbx(1'b1, a, d, r);
    endtask : wr

    task automatic unlock();
        wr(FCS_KEY_OFS, 32'(FCS_KEY1));
        wr(FCS_KEY_OFS, 32'(FCS_KEY2));
    endtask : unlock

    // Poll status until the done flag shows
    task automatic wait_done(output logic [31:0] s);
        s = '0;
        repeat (1500) if (s[FCS_ST_DONE] !== 1'b1) wbx(1'b0, FCS_STAT_OFS, '0, s);
        chk(64'(s[FCS_ST_DONE]), 64'h1);
    endtask : wait_done

    // Command optionally unlocked, then waited for
    task automatic run(input logic k, input logic [3:0] c, output logic [31:0] s);
        if (k) unlock();
        r0 = readCnt;
        wr(FCS_CMD_OFS, {28'h0, c});
        wait_done(s);
    endtask : run

    task automatic prog(input logic [31:0] a, input logic [63:0] d);
        wr(FCS_WADDR_OFS, a);
        wr(FCS_WDATL_OFS, d[31:0]);
        wr(FCS_WDATH_OFS, d[63:32]);
        run(1'b0, FCS_CMD_WRITE, st);
    endtask : prog

    // Refused command: no erase pulse and not busy afterwards
    task automatic refused(input logic [3:0] c);
        n0 = eraseCnt;
        wr(FCS_CMD_OFS, {28'h0, c});
        repeat (20) @(posedge clk);
        wbx(1'b0, FCS_STAT_OFS, '0, q);
        chk(64'(eraseCnt - n0), 64'h0);
        chk(64'(q[FCS_ST_BUSY]), 64'h0);
    endtask : refused

    // Expected signature: XOR of word halves, stored half left out
    function automatic logic [31:0] sig_of(input logic [31:0] a, input logic [31:0] b);
        logic [63:0] w;
        logic [31:0] s;
        s = '0;
        for (logic [31:0] x = a; x < b + 32'h40; x += 32'h8) begin
            w = u_mem.rdw(x);
            s = s ^ w[31:0] ^ ((x == b + 32'h38) ? 32'h0 : w[63:32]);
        end
        return s;
    endfunction : sig_of

    task automatic sign(input logic [31:0] a, input logic [31:0] b);
        logic [63:0] last;
        wr(FCS_PSTART_OFS, a);
        wr(FCS_PEND_OFS, b);
        run(1'b1, FCS_CMD_SIGN, st);
        wbx(1'b0, FCS_SIGN_OFS, '0, sg);
        last = u_mem.rdw(b + 32'h38);
        chk(64'(sg), 64'(sig_of(a, b)));
        chk(64'(st[FCS_ST_RES +: 2]), 64'((sg == last[63:32]) ? FCS_RES_OK : FCS_RES_VERR));
        chk(64'(readCnt - r0), 64'((b - a + 32'h40) >> 3));
    endtask : sign

    task automatic endOfTest();
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : endOfTest

    // Flash request monitor and run limit
    always @(posedge clk) begin
        cycles++;
        if (flashReq.erase === 1'b1) eraseCnt++;
        if (failIrq === 1'b1) irqCnt++;
        if (flashReq.rd === 1'b1) begin
            readCnt++;
            if (chkEcc) chk(64'(flashReq.eccOn), 64'(expEcc));
        end
        if (cycles == 40000) begin
            errCount++;
            endOfTest();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; wdat = '0;
        lat = 4'h1; stuckAddr = 32'h1; eccCode = 2'h0; chkEcc = 1'b0; expEcc = 1'b0;
        errCount = 0; compares = 0; eraseCnt = 0; readCnt = 0; irqCnt = 0; cycles = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        wbx(1'b0, FCS_CTRL_OFS, '0, q);
        chk(64'(q), 64'(FCS_CTRL_RST));
        wbx(1'b0, 8'h3c, '0, q);
        chk(64'(q), 64'h0);
        wr(FCS_PSTART_OFS, 32'h100);
        refused(FCS_CMD_PAGE);
        wr(FCS_KEY_OFS, 32'(FCS_KEY2));
        wr(FCS_KEY_OFS, 32'(FCS_KEY1));
        refused(FCS_CMD_PAGE);
        unlock();
        refused(FCS_CMD_IDLE);
        prog(32'h108, 64'h0000_00ff_1234_5678);
        chk(u_mem.rdw(32'h108), 64'h0000_00ff_1234_5678);
        wr(FCS_WADDR_OFS, FCS_PROT_ADDR);
        wr(FCS_WDATL_OFS, 32'h0);
        wr(FCS_WDATH_OFS, 32'h0);
        refused(FCS_CMD_WRITE);
        chk(u_mem.rdw(FCS_PROT_ADDR), '1);
        run(1'b1, FCS_CMD_WRITE, st);
        chk(u_mem.rdw(FCS_PROT_ADDR), 64'h0);
        chkEcc = 1'b1;
        run(1'b1, FCS_CMD_PAGE, st);
        chk(u_mem.rdw(32'h108), '1);
        chk(64'(readCnt - r0), 64'h8);
        chk(64'(st[FCS_ST_RES +: 2]), 64'(FCS_RES_OK));
        prog(32'h110, 64'h0);
        stuckAddr = 32'h110;
        lat = 4'h5;
        unlock();
        run(1'b1, FCS_CMD_PAGE, st);
        chk(64'(st[FCS_ST_RES +: 2]), 64'(FCS_RES_VERR));
        stuckAddr = 32'h1;
        lat = 4'h2;
        prog(32'h0, 64'h0);
        prog(PB, 64'h0);
        run(1'b1, FCS_CMD_MPROG, st);
        chk(u_mem.rdw(32'h0), '1);
        chk(u_mem.rdw(PB), 64'h0);
        chk(64'(readCnt - r0), 64'(PB >> 3));
        chk(64'(st[FCS_ST_RES +: 2]), 64'(FCS_RES_OK));
        prog(DB + 32'h7f8, 64'h0);
        prog(DB + 32'h800, 64'h0);
        run(1'b1, FCS_CMD_MDATA, st);
        chk(u_mem.rdw(DB + 32'h7f8), '1);
        chk(u_mem.rdw(DB + 32'h800), 64'h0);
        chk(64'(readCnt - r0), 64'(FCS_DHALF_BYTES / FCS_WORD_BYTES));
        prog(DB + 32'h8, 64'h0);
        stuckAddr = DB + 32'h8;
        run(1'b1, FCS_CMD_MDATA, st);
        chk(64'(st[FCS_ST_RES +: 2]), 64'(FCS_RES_VERR));
        stuckAddr = 32'h1;
        expEcc = 1'b1;
        sign(32'h200, 32'h200);
        prog(32'h210, 64'hffff_ffff_0000_0000);
        wr(FCS_CTRL_OFS, 32'h0000_0014);
        eccCode = 2'h2;
        n0 = irqCnt;
        sign(32'h200, 32'h240);
        chk(64'(st[FCS_ST_ECC +: 2]), 64'h2);
        // One pulse per erroneous read: 16 words signed
        chk(64'(irqCnt - n0), 64'h10);
        wbx(1'b0, FCS_PECC_OFS, '0, q);
        chk(64'(q), 64'h0);
        wbx(1'b0, FCS_DECC_OFS, '0, q);
        chk(64'(q), 64'h0);
        wr(FCS_CTRL_OFS, 32'(FCS_CTRL_RST));
        sign(32'h200, 32'h240);
        chk(64'(irqCnt - n0), 64'h10);
        endOfTest();
    end
endmodule : fcs_sequencer_bench
